// File: design/cs_tx_defines.vh
// Register map and field layout constants for the control symbol request bank
`ifndef CS_TX_DEFINES_VH
`define CS_TX_DEFINES_VH

// ***************************************************************
// Register map: two words per port, port stride 0x10
// ***************************************************************
`define NUM_PORTS          4
`define PORT_IDX_W         2
`define PORT_STRIDE_LSB    4
`define OFS_MCAST_TRIGGER  4'h0
`define OFS_CS_FIELDS      4'h4
`define FIELDS_RESET       32'h00000000
`define FIELDS_LIVE_RESET  20'h00000
`define READ_ZERO          32'h00000000

// ***************************************************************
// Field positions in the transmit fields register
// ***************************************************************
`define STYPE0_HI          31
`define STYPE0_LO          29
`define PARAM1_HI          28
`define PARAM1_LO          24
`define PARAM2_HI          23
`define PARAM2_LO          19
`define STYPE1_HI          18
`define STYPE1_LO          16
`define CMD_HI             15
`define CMD_LO             13
`define EMBED_BIT          12
`define FIELDS_LIVE_W      20
`define FIELDS_LIVE_LO     12
`define RSVD_W             12

// ***************************************************************
// Symbol request encoding on the outbound side
// ***************************************************************
`define REQ_KIND_MCAST     1'b1
`define REQ_KIND_FIELDS    1'b0

`endif

// File: design/cs_port_slot.v
// One port's request slot: holds a pending symbol until the link takes it
`timescale 1ns/1ns
`default_nettype none
`include "cs_tx_defines.vh"

module cs_port_slot (
  input  wire        clk,
  input  wire        rstn,
  input  wire        set_mcast,
  input  wire        set_fields,
  input  wire        take,
  output reg         pending,
  output reg         kind
);

  // ***************************************************************
  // Pending flag; a new request in the take cycle is kept
  // ***************************************************************
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pending <= 1'b0;
      kind    <= `REQ_KIND_FIELDS;
    end else if (set_mcast || set_fields) begin
      pending <= 1'b1;                   // Set wins over take
      kind    <= set_mcast ? `REQ_KIND_MCAST : `REQ_KIND_FIELDS;
    end else if (take) begin
      pending <= 1'b0;
    end
  end

endmodule // cs_port_slot
`default_nettype wire

// File: design/control_symbol_tx_request.v
// APB register bank that requests control symbols on four serial ports
// Behaviour
// RULE1 - Each trigger write sends one multicast symbol, data ignored. A trigger while the port's symbol is still pending merges with it.
// RULE2 - The multicast trigger register always reads as zero.
// RULE3 - Each of the four ports has its own transmit fields register.
// RULE4 - Bits 31 to 29 hold the stype0 encoding that carries both parameters.
// RULE5 - Bits 28 to 24 and 23 to 19 hold two parameters sent with stype0.
// RULE6 - Bits 18 to 16 hold the stype1 encoding that uses the command field.
// RULE7 - Bits 15 to 13 hold the command that with stype1 picks the command.
// RULE8 - With the embed bit 12 set the symbol is inserted inside a packet.
// RULE9 - Without embed symbols go at packet gaps; bits 11 to 0 read zero.
`timescale 1ns/1ns
`default_nettype none
`include "cs_tx_defines.vh"

module control_symbol_tx_request (
  input  wire        clk,
  input  wire        rstn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [3:0]  link_in_packet,
  input  wire [3:0]  link_symbol_ack,
  output reg  [3:0]  symbol_req,
  output reg  [3:0]  symbol_is_mcast,
  output reg  [3:0]  symbol_embed,
  output reg  [2:0]  symbol_stype0,
  output reg  [4:0]  symbol_param_first,
  output reg  [4:0]  symbol_param_second,
  output reg  [2:0]  symbol_stype1,
  output reg  [2:0]  symbol_cmd
);

  // ***************************************************************
  // Address decode
  // ***************************************************************
  wire       setup      = psel && !penable;
  wire [1:0] port_sel   = paddr[`PORT_STRIDE_LSB+`PORT_IDX_W-1:
                                `PORT_STRIDE_LSB];
  wire [3:0] word_ofs   = paddr[`PORT_STRIDE_LSB-1:0];
  wire       hi_zero    = ~|paddr[31:`PORT_STRIDE_LSB+`PORT_IDX_W];
  wire       hit_mcast  = hi_zero && (word_ofs == `OFS_MCAST_TRIGGER);
  wire       hit_fields = hi_zero && (word_ofs == `OFS_CS_FIELDS);
  wire       wr_now     = setup && pwrite;

  // Live field bits of all ports, one slice per port; reserved low
  // bits are never stored, so they cost no flops and read as zero
  wire [`NUM_PORTS*`FIELDS_LIVE_W-1:0] fields_all;
  wire [`NUM_PORTS-1:0]                pending;
  wire [`NUM_PORTS-1:0]                kind;
  reg  [`NUM_PORTS-1:0]                take;

  // ***************************************************************
  // Per-port storage and request slots
  // ***************************************************************
  genvar g;
  generate
    for (g = 0; g < `NUM_PORTS; g = g + 1) begin : port
      localparam integer PORT_ID = g;
      wire                      sel;
      reg  [`FIELDS_LIVE_W-1:0] store;
      assign sel = (port_sel == PORT_ID[`PORT_IDX_W-1:0]);
      // Independent copy for each port, see RULE3
      always @(posedge clk or negedge rstn) begin
        if (!rstn)
          store <= `FIELDS_LIVE_RESET;
        else if (wr_now && hit_fields && sel)
          store <= pwdata[`STYPE0_HI:`FIELDS_LIVE_LO]; // see RULE9
      end
      // Each slice has exactly one driver
      assign fields_all[g*`FIELDS_LIVE_W +: `FIELDS_LIVE_W] = store;
      // Trigger write sets the port's multicast request, merged into one already pending, see RULE1
      cs_port_slot u_slot (
        .clk        (clk),
        .rstn       (rstn),
        .set_mcast  (wr_now && hit_mcast && sel),
        .set_fields (1'b0),
        .take       (take[g]),
        .pending    (pending[g]),
        .kind       (kind[g])
      );
    end
  endgenerate

  // ***************************************************************
  // Link boundary input; the link runs on this clock, so no sync
  // ***************************************************************
  // Embedded symbols go any time; others wait for a packet gap,
  // which trades latency for never splitting a packet by accident
  integer i;
  always @* begin
    take = 4'h0;
    for (i = 0; i < `NUM_PORTS; i = i + 1)
      take[i] = symbol_req[i] && link_symbol_ack[i];
  end

  // ***************************************************************
  // Outbound request selection
  // ***************************************************************
  // Shared field bus shows the lowest pending port's fields
  reg [`PORT_IDX_W-1:0] next_port;
  reg                   next_any;
  integer               k;
  always @* begin
    next_port = {`PORT_IDX_W{1'b0}};
    next_any  = 1'b0;
    for (k = `NUM_PORTS - 1; k >= 0; k = k - 1)
      if (pending[k]) begin
        next_port = k[`PORT_IDX_W-1:0];
        next_any  = 1'b1;
      end
  end

  wire [`FIELDS_LIVE_W-1:0] f =
    fields_all[next_port*`FIELDS_LIVE_W +: `FIELDS_LIVE_W];
  wire f_embed = f[`EMBED_BIT-`FIELDS_LIVE_LO];

  // A request starts only at a packet gap unless it is embedded
  wire launch = next_any &&
                (f_embed || !link_in_packet[next_port]); // see RULE9
  wire taken  = |take;

  // ***************************************************************
  // Offer state machine
  // ***************************************************************
  // Once offered, a symbol stands until the link takes it: the link
  // answers a cycle late, so a request that came and went could be
  // lost or be acknowledged for a symbol no longer shown
  localparam [1:0] ST_IDLE  = 2'b01;
  localparam [1:0] ST_OFFER = 2'b10;
  reg [1:0] state;
  reg [1:0] next_state;

  // Next state: idle until a launch, offer until the link takes it
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (launch)
          next_state = ST_OFFER;
      end
      ST_OFFER: begin
        if (taken)
          next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // State register
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // ***************************************************************
  // Outbound symbol registers
  // ***************************************************************
  // Fields are copied at launch and held, so a fields write during
  // the offer cannot change a symbol already on its way; the cost is
  // one idle cycle between two symbols
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      symbol_req          <= 4'h0;
      symbol_is_mcast     <= 4'h0;
      symbol_embed        <= 4'h0;
      symbol_stype0       <= 3'h0;
      symbol_param_first  <= 5'h0;
      symbol_param_second <= 5'h0;
      symbol_stype1       <= 3'h0;
      symbol_cmd          <= 3'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (launch) begin
            symbol_req[next_port]      <= 1'b1;
            symbol_is_mcast[next_port] <= kind[next_port];
            symbol_embed[next_port]    <= f_embed;        // see RULE8
            symbol_stype0       <= f[`STYPE0_HI-`FIELDS_LIVE_LO:
                                     `STYPE0_LO-`FIELDS_LIVE_LO]; // see RULE4
            symbol_param_first  <= f[`PARAM1_HI-`FIELDS_LIVE_LO:
                                     `PARAM1_LO-`FIELDS_LIVE_LO]; // see RULE5
            symbol_param_second <= f[`PARAM2_HI-`FIELDS_LIVE_LO:
                                     `PARAM2_LO-`FIELDS_LIVE_LO]; // see RULE5
            symbol_stype1       <= f[`STYPE1_HI-`FIELDS_LIVE_LO:
                                     `STYPE1_LO-`FIELDS_LIVE_LO]; // see RULE6
            symbol_cmd          <= f[`CMD_HI-`FIELDS_LIVE_LO:
                                     `CMD_LO-`FIELDS_LIVE_LO];    // see RULE7
          end
        end
        ST_OFFER: begin
          // The ack cycle ends the offer, one symbol per pending request
          if (taken) begin
            symbol_req      <= 4'h0;                      // see RULE1
            symbol_is_mcast <= 4'h0;
            symbol_embed    <= 4'h0;
          end
        end
        default: begin
          symbol_req      <= 4'h0;
          symbol_is_mcast <= 4'h0;
          symbol_embed    <= 4'h0;
        end
      endcase
    end
  end

  // ***************************************************************
  // APB answer: no wait states, read data registered
  // ***************************************************************
  // Addressed port's live bits; reserved bits are padded on read
  wire [`FIELDS_LIVE_W-1:0] rd_fields =
    fields_all[port_sel*`FIELDS_LIVE_W +: `FIELDS_LIVE_W];

  // Answer registers; an unmapped address errors and reads zero
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata  <= `READ_ZERO;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !(hit_mcast || hit_fields);
      if (setup && !pwrite && hit_fields)
        prdata <= {rd_fields, {`RSVD_W{1'b0}}};        // see RULE9
      else
        prdata <= `READ_ZERO;                          // see RULE2
    end
  end

endmodule // control_symbol_tx_request
`default_nettype wire

// File: dv/cs_tx_chk.sv
// Port assertions for the control symbol request bank
`timescale 1ns/1ns
`default_nettype none
module cs_tx_chk (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  link_in_packet,
  input wire logic [3:0]  link_symbol_ack,
  input wire logic [3:0]  symbol_req,
  input wire logic [3:0]  symbol_embed
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Trigger write seen at its setup edge
  wire trig = psel && !penable && pwrite && paddr[31:6] == 26'h0
              && paddr[3:0] == 4'h0;
  property p_ans; psel && !penable |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_send; trig |-> ##[1:80] |symbol_req; endproperty
  a_send: assert property (p_send) else $error("no symbol");
  property p_rdz; pready && paddr[3:0] == 4'h0 |-> prdata == 32'h0;
  endproperty
  a_rdz: assert property (p_rdz) else $error("trigger read");
  property p_one; |symbol_req |-> $onehot(symbol_req); endproperty
  a_one: assert property (p_one) else $error("two ports");
  property p_hold; |symbol_req && !(|(symbol_req & link_symbol_ack))
    |=> $stable(symbol_req) && $stable(symbol_embed); endproperty
  a_hold: assert property (p_hold) else $error("req lost");
  property p_drop; |(symbol_req & link_symbol_ack)
    |=> (symbol_req & $past(symbol_req)) == 4'h0; endproperty
  a_drop: assert property (p_drop) else $error("req kept");
  // A packet in flight holds back symbols that are not embedded
  property p_bnd; $rose(|symbol_req) |->
    (symbol_req & ~symbol_embed & $past(link_in_packet)) == 4'h0; endproperty
  a_bnd: assert property (p_bnd) else $error("mid packet");
  property p_rsv; pready && paddr[3:0] == 4'h4 |-> prdata[11:0] == 12'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits");
  c_emb: cover property (|(symbol_req & symbol_embed & link_in_packet));
  c_trig: cover property (trig);
  c_err: cover property (pready && pslverr);
endmodule // cs_tx_chk
bind control_symbol_tx_request cs_tx_chk chk (
  .clk             (clk),
  .rstn            (rstn),
  .psel            (psel),
  .penable         (penable),
  .pwrite          (pwrite),
  .paddr           (paddr),
  .prdata          (prdata),
  .pready          (pready),
  .pslverr         (pslverr),
  .link_in_packet  (link_in_packet),
  .link_symbol_ack (link_symbol_ack),
  .symbol_req      (symbol_req),
  .symbol_embed    (symbol_embed)
);
`default_nettype wire

// File: dv/link_partner.sv
// Behavioural link partner: packet traffic and symbol acknowledges
`timescale 1ns/1ns
`default_nettype none
module link_partner (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [3:0] symbol_req,
  output var  logic [3:0] link_in_packet,
  output var  logic [3:0] link_symbol_ack
);
  integer     seed = 32'hAAC0;
  logic [7:0] r;
  // Packets come and go; an ack comes one cycle after the request or later, never twice
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      link_in_packet  <= 4'h0;
      link_symbol_ack <= 4'h0;
    end else begin
      r = $random(seed);
      link_in_packet  <= r[3:0] & r[7:4];
      link_symbol_ack <= symbol_req & ~link_symbol_ack & {4{r[0]}};
    end
  end
endmodule // link_partner
`default_nettype wire

// File: dv/testbench.sv
// Random and corner tests of the control symbol request bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pready, pslverr, er;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd, v, f [4];
  logic [3:0]  link_in_packet, link_symbol_ack, symbol_req;
  logic [3:0]  symbol_is_mcast, symbol_embed;
  logic [2:0]  symbol_stype0, symbol_stype1, symbol_cmd;
  logic [4:0]  symbol_param_first, symbol_param_second;
  integer      seed = 32'hAAC0, err_count = 0, cmp_count = 0, i, p, n;
  initial forever #5 clk = ~clk;
  control_symbol_tx_request dut (.*);
  link_partner partner (.*);
  // Reserved low bits never hold data
  function automatic logic [31:0] fields_exp(input logic [31:0] d);
    return d & 32'hFFFFF000;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; an idle edge after it keeps drivers single-valued
  task automatic apb(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk) penable <= 1'b1;
    n = 0;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) err_count++;
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge clk);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Reset values, then field writes and triggers on random ports
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (p = 0; p < 4; p++) begin
      apb(1'b0, p * 16 + 4, 32'h0);
      check(rd, 32'h0);
      f[p] = 32'h0;
    end
    $display("reset test done");
    for (i = 0; i < 16; i++) begin
      p = i < 4 ? i : $random(seed) & 3;
      v = i == 0 ? 32'hFFFFFFFF : $random(seed);
      f[p] = fields_exp(v);
      apb(1'b1, p * 16 + 4, v);
      apb(1'b0, p * 16 + 4, 32'h0);
      check(rd, f[p]);
      apb(1'b1, p * 16, $random(seed));
      for (n = 0; symbol_req[p] !== 1'b1 && n < 80; n++) @(posedge clk);
      check(symbol_req[p], 1'b1);
      check(symbol_stype0, f[p][31:29]);
      check(symbol_param_first, f[p][28:24]);
      check(symbol_param_second, f[p][23:19]);
      check(symbol_stype1, f[p][18:16]);
      check(symbol_cmd, f[p][15:13]);
      check(symbol_embed[p], f[p][12]);
      check(symbol_is_mcast[p], 1'b1);
      for (n = 0; symbol_req !== 4'h0 && n < 80; n++) @(posedge clk);
      check(symbol_req, 4'h0);
      apb(1'b0, p * 16, 32'h0);
      check(rd, 32'h0);
      $display("symbol test %0d done", i);
    end
    for (p = 0; p < 4; p++) begin
      apb(1'b0, p * 16 + 4, 32'h0);
      check(rd, f[p]);
    end
    $display("readback test done");
    apb(1'b0, 32'h8, 32'h0);
    check(er, 1'b1);
    $display("unmapped test done");
    end_of_test;
  end
  // Cut a hang short
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_of_test;
  end
endmodule // testbench
`default_nettype wire
